// *** pkg/target_sel_pkg.sv ***
package target_sel_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses on APB)
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] ROUTE_OFFSET = 8'h04;
    localparam logic [7:0] STATUS_OFFSET = 8'h08;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_MODE_BIT = 0;
    localparam int CTRL_STEP_FORWARD_EN_BIT = 1;
    localparam int CTRL_STEP_BACKWARD_EN_BIT = 2;
    localparam int CTRL_STEP_HOME_EN_BIT = 3;
    localparam int CTRL_SEL2_ROUTED_BIT = 4;
    localparam logic [4:0] CTRL_RESET = 5'h00;

    // Route register: input number (0..15) for each signal, 4 bits each
    localparam int ROUTE_SEL0_LSB = 0;
    localparam int ROUTE_SEL1_LSB = 4;
    localparam int ROUTE_SEL2_LSB = 8;
    localparam int ROUTE_TRIG_LSB = 12;
    localparam logic [3:0] DEF_SEL0_INPUT = 4'h7;
    localparam logic [3:0] DEF_SEL1_INPUT = 4'h8;
    localparam logic [3:0] DEF_SEL2_INPUT = 4'h0;
    localparam logic [3:0] DEF_TRIG_INPUT = 4'h6;

    localparam int STATUS_CUR_LSB = 0;
    localparam int STATUS_CMD_LSB = 4;
    localparam int STATUS_BUSY_BIT = 8;

    localparam int NUM_INPUTS = 16;
    localparam int NUM_TARGETS = 8;
    localparam logic [2:0] FIRST_TARGET = 3'h0;
    localparam logic [2:0] LAST_TARGET = 3'h7;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic step_forward;
        logic step_backward;
        logic step_home;
    } step_inputs_t;

    typedef struct packed {
        logic start;
        logic [2:0] index;
    } move_cmd_t;

    typedef enum logic [1:0] {IDLE, MOVING} move_state_t;

endpackage : target_sel_pkg

// *** rtl/fixed_position_target_selector.sv ***
// Behaviour
// - Targets chosen by select code plus trigger edge, or by step edges.
// - Select bits 2..0 form binary code; 000 is target 1, 111 target 8.
// - Select bit 2 unrouted reads as 0, limiting choice to targets 1-4.
// - Trigger rising edge starts a move to the selected target.
// - Default routing: bit0 input 7, bit1 input 8, trigger input 6.
// - Enabled step-forward edge moves to current index plus one.
// - Enabled step-backward edge moves to current index minus one.
// - Enabled step-home edge moves to target 1.
// - Step edges are ignored unless the motor is at standstill.
// - Step-forward ignored at target 8, no move started.
// - At target 1 step-backward ignored, step-home still acts.
// - Motor resting mid-move makes commanded target the current index.
`timescale 1ns/100ps
module fixed_position_target_selector
    import target_sel_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Digital inputs from the controller, asynchronous
    input wire logic [NUM_INPUTS-1:0] digital_input,
    input wire target_sel_pkg::step_inputs_t step_in,
    // Motion core
    input wire logic motor_standstill,
    input wire logic move_done,
    output target_sel_pkg::move_cmd_t move_cmd,
    output logic [2:0] current_index,
    output logic move_busy
);
    import target_sel_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic rising(input logic now, input logic prev);
        return now & ~prev;
    endfunction : rising

    function automatic logic pick(input logic [NUM_INPUTS-1:0] v, input logic [3:0] sel);
        return v[sel];
    endfunction : pick

    // ------------------------------------------------------------
    // Register decode and step arithmetic
    // ------------------------------------------------------------
    typedef enum logic [1:0] {HIT_CTRL, HIT_ROUTE, HIT_STATUS, HIT_NONE} reg_hit_t;

    function automatic reg_hit_t decode(input logic [7:0] addr);
        reg_hit_t hit;
        case (addr)
            CTRL_OFFSET: begin
                hit = HIT_CTRL;
            end
            ROUTE_OFFSET: begin
                hit = HIT_ROUTE;
            end
            STATUS_OFFSET: begin
                hit = HIT_STATUS;
            end
            default: begin
                hit = HIT_NONE;
            end
        endcase
        return hit;
    endfunction : decode

    // Neighbouring target; the ends of the table are held, the caller refuses the move
    function automatic logic [2:0] step_target(input logic [2:0] cur, input logic up);
        logic [2:0] tgt;
        tgt = cur;
        if (up) begin
            if (cur != LAST_TARGET) begin
                tgt = cur + 3'h1;
            end
        end else begin
            if (cur != FIRST_TARGET) begin
                tgt = cur - 3'h1;
            end
        end
        return tgt;
    endfunction : step_target

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [4:0] ctrl_reg;
    logic [15:0] route_reg;
    logic internal_positioning_mode;
    logic step_forward_en;
    logic step_backward_en;
    logic step_home_en;
    logic sel2_routed;

    assign internal_positioning_mode = ctrl_reg[CTRL_MODE_BIT];
    assign step_forward_en = ctrl_reg[CTRL_STEP_FORWARD_EN_BIT];
    assign step_backward_en = ctrl_reg[CTRL_STEP_BACKWARD_EN_BIT];
    assign step_home_en = ctrl_reg[CTRL_STEP_HOME_EN_BIT];
    assign sel2_routed = ctrl_reg[CTRL_SEL2_ROUTED_BIT];

    logic wr_en, rd_en;
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;

    // Zero-wait slave: pready high in every access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= CTRL_RESET;
            route_reg <= {DEF_TRIG_INPUT, DEF_SEL2_INPUT, DEF_SEL1_INPUT, DEF_SEL0_INPUT};
        end else if (wr_en) begin
            case (decode(paddr))
                HIT_CTRL: begin
                    ctrl_reg <= pwdata[4:0];
                end
                HIT_ROUTE: begin
                    route_reg <= pwdata[15:0];
                end
                default: begin
                    // Status is read-only; other offsets take no write
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel & ~penable;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [31:0] read_word;
    logic read_err;
    always_comb begin
        read_word = 32'h0000_0000;
        read_err = 1'b0;
        case (decode(paddr))
            HIT_CTRL: begin
                read_word[4:0] = ctrl_reg;
            end
            HIT_ROUTE: begin
                read_word[15:0] = route_reg;
            end
            HIT_STATUS: begin
                read_word[STATUS_CUR_LSB +: 3] = current_index;
                read_word[STATUS_CMD_LSB +: 3] = move_cmd.index;
                read_word[STATUS_BUSY_BIT] = move_busy;
            end
            default: begin
                read_err = 1'b1;
            end
        endcase
    end

    // Latched at the setup edge; an unmapped address answers pslverr and zero data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel & ~penable) begin
            prdata <= read_word;
            pslverr <= read_err;
        end
    end

    // ------------------------------------------------------------
    // Input synchronisers and edge detect
    // ------------------------------------------------------------
    // First stage is read only by the second stage
    logic [NUM_INPUTS-1:0] din_meta, din_sync;
    step_inputs_t step_meta, step_sync;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            din_meta <= '0;
            din_sync <= '0;
            step_meta <= '0;
            step_sync <= '0;
        end else begin
            din_meta <= digital_input;
            din_sync <= din_meta;
            step_meta <= step_in;
            step_sync <= step_meta;
        end
    end

    // Each input keeps its own last sample: rerouting the trigger cannot fake an edge
    logic [NUM_INPUTS-1:0] din_prev;
    logic [3:0] trig_input;
    logic trig_now, trig_prev;
    step_inputs_t step_prev;
    assign trig_input = route_reg[ROUTE_TRIG_LSB +: 4];
    assign trig_now = pick(din_sync, trig_input);
    assign trig_prev = pick(din_prev, trig_input);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            din_prev <= '0;
            step_prev <= '0;
        end else begin
            din_prev <= din_sync;
            step_prev <= step_sync;
        end
    end

    logic trig_edge, fwd_edge, bwd_edge, home_edge;
    assign trig_edge = rising(trig_now, trig_prev);
    assign fwd_edge = rising(step_sync.step_forward, step_prev.step_forward);
    assign bwd_edge = rising(step_sync.step_backward, step_prev.step_backward);
    assign home_edge = rising(step_sync.step_home, step_prev.step_home);

    // ------------------------------------------------------------
    // Target selection
    // ------------------------------------------------------------
    logic [2:0] sel_code;
    always_comb begin
        sel_code[0] = pick(din_sync, route_reg[ROUTE_SEL0_LSB +: 4]);
        sel_code[1] = pick(din_sync, route_reg[ROUTE_SEL1_LSB +: 4]);
        // Unrouted bit 2 forces code into targets 1-4
        sel_code[2] = sel2_routed & pick(din_sync, route_reg[ROUTE_SEL2_LSB +: 4]);
    end

    // ------------------------------------------------------------
    // Move request
    // ------------------------------------------------------------
    // Index 0 stands for target 1, 7 for target 8
    logic req_valid;
    logic [2:0] req_index;
    always_comb begin
        req_valid = 1'b0;
        req_index = current_index;
        if (internal_positioning_mode) begin
            // The trigger names an absolute target, so it needs no standstill
            if (trig_edge) begin
                req_valid = 1'b1;
                req_index = sel_code;
            end else if (motor_standstill) begin
                // Home before forward and backward: it is the safe choice when step edges coincide
                if (step_home_en && home_edge) begin
                    req_valid = 1'b1;
                    req_index = FIRST_TARGET;
                end else if (step_forward_en && fwd_edge && current_index != LAST_TARGET) begin
                    req_valid = 1'b1;
                    req_index = step_target(current_index, 1'b1);
                end else if (step_backward_en && bwd_edge
                             && current_index != FIRST_TARGET) begin
                    req_valid = 1'b1;
                    req_index = step_target(current_index, 1'b0);
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Move sequencing
    // ------------------------------------------------------------
    move_state_t state_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= IDLE;
            move_cmd <= '0;
            current_index <= FIRST_TARGET;
            move_busy <= 1'b0;
        end else begin
            move_cmd.start <= 1'b0;
            case (state_reg)
                IDLE: begin
                    if (req_valid) begin
                        move_cmd.start <= 1'b1;
                        move_cmd.index <= req_index;
                        move_busy <= 1'b1;
                        state_reg <= MOVING;
                    end
                end
                MOVING: begin
                    // Edges seen while a move runs are dropped, not queued
                    // A normal finish or an unexpected stop both land here
                    if (move_done) begin
                        current_index <= move_cmd.index;
                        move_busy <= 1'b0;
                        state_reg <= IDLE;
                    end
                end
                default: begin
                    state_reg <= IDLE;
                end
            endcase
        end
    end

endmodule : fixed_position_target_selector

// *** verification/target_sel_properties.sv ***
`timescale 1ns/100ps
module target_sel_properties
    import target_sel_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic move_done,
    input wire target_sel_pkg::move_cmd_t move_cmd,
    input wire logic [2:0] current_index,
    input wire logic move_busy
);
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    AST_START_ONE: assert property (move_cmd.start |=> !move_cmd.start)
        else $error("start pulse too long");
    AST_START_BUSY: assert property (move_cmd.start |-> move_busy && !$past(move_busy))
        else $error("start without fresh busy");
    AST_NO_START_BUSY: assert property (move_busy && $past(move_busy) |-> !move_cmd.start)
        else $error("start while moving");
    AST_INDEX_HOLD: assert property (move_busy && !move_cmd.start |-> $stable(move_cmd.index))
        else $error("target changed during move");
    AST_DONE_TAKE: assert property (move_busy && move_done |=>
        !move_busy && current_index == $past(move_cmd.index))
        else $error("end of move not taken");
    AST_CUR_HOLD: assert property (!(move_busy && move_done) |=> $stable(current_index))
        else $error("current index moved");
    AST_PREADY: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready timing");
    AST_SLVERR: assert property (pready && paddr > 8'h08 |-> pslverr)
        else $error("unmapped not refused");
    AST_NO_SLVERR: assert property (pready && paddr inside {8'h00, 8'h04, 8'h08} |-> !pslverr)
        else $error("mapped refused");
endmodule : target_sel_properties

bind fixed_position_target_selector target_sel_properties i_props (.pclk, .presetn, .psel,
    .penable, .paddr, .pready, .pslverr, .move_done, .move_cmd, .current_index, .move_busy);

// *** verification/motion_model.sv ***
`timescale 1ns/100ps
module motion_model
    import target_sel_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire target_sel_pkg::move_cmd_t move_cmd,
    input wire logic [3:0] move_len,
    input wire logic fault_stop,
    input wire logic drift,
    output logic move_done,
    output logic motor_standstill
);
    logic [3:0] count_reg;
    logic at_rest_reg;
    // Drift: the shaft is turned from outside while no move runs
    assign motor_standstill = at_rest_reg & ~drift;
    // ----------------------------------------
    // Move timing, a fault stop reports like a finished move
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= 4'h0;
            move_done <= 1'b0;
            at_rest_reg <= 1'b1;
        end else begin
            move_done <= (count_reg == 4'h1);
            if (move_cmd.start) begin
                count_reg <= move_len;
                at_rest_reg <= 1'b0;
            end else if (fault_stop && count_reg > 4'h1) begin
                count_reg <= 4'h1;
            end else if (count_reg != 4'h0) begin
                count_reg <= count_reg - 4'h1;
            end
            if (count_reg == 4'h1) at_rest_reg <= 1'b1;
        end
    end
endmodule : motion_model

// *** verification/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
    import target_sel_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [NUM_INPUTS-1:0] digital_input = '0;
    step_inputs_t step_in = '0;
    logic motor_standstill;
    logic move_done;
    move_cmd_t move_cmd;
    logic [2:0] current_index;
    logic move_busy;
    logic [3:0] move_len = 4'h3;
    logic fault_stop = 1'b0;
    logic drift = 1'b0;
    logic [31:0] rd;
    logic rd_err;
    int errors = 0;
    int tests_run = 0;
    always #5 pclk = ~pclk;
    fixed_position_target_selector i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .digital_input, .step_in, .motor_standstill,
        .move_done, .move_cmd, .current_index, .move_busy);
    motion_model i_motion (.pclk, .presetn, .move_cmd, .move_len, .fault_stop, .drift,
        .move_done, .motor_standstill);
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic end_of_test;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            errors++;
            end_of_test();
        end
        rd = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rdc
    // Mask bits: 3 forward, 2 backward, 1 home, 0 trigger
    task automatic press(input logic [3:0] m, input logic go, input logic [2:0] idx);
        int n;
        digital_input[6] <= m[0];
        step_in <= m[3:1];
        for (n = 0; n < 10; n++) begin
            @(posedge pclk);
            if (move_cmd.start === 1'b1) break;
        end
        digital_input[6] <= 1'b0;
        step_in <= 3'h0;
        chk({31'h0, n < 10}, {31'h0, go});
        if (go) chk({29'h0, move_cmd.index}, {29'h0, idx});
        for (n = 0; n < 40 && move_busy !== 1'b0; n++) @(posedge pclk);
        if (move_busy !== 1'b0) begin
            errors++;
            end_of_test();
        end
        if (go) chk({29'h0, current_index}, {29'h0, idx});
        repeat (4) @(posedge pclk);
    endtask : press
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(CTRL_OFFSET, 32'h0);
        rdc(ROUTE_OFFSET, 32'h6087);
        rdc(STATUS_OFFSET, 32'h0);
        rdc(8'h0c, 32'h0);
        chk({31'h0, rd_err}, 32'h1);
        apb(1'b1, CTRL_OFFSET, 32'h1f);
        rdc(CTRL_OFFSET, 32'h1f);
        for (int c = 0; c < 8; c++) begin
            digital_input[7] <= c[0];
            digital_input[8] <= c[1];
            digital_input[0] <= c[2];
            move_len <= c[3:0] + 4'h3;
            repeat (3) @(posedge pclk);
            press(4'h1, 1'b1, c[2:0]);
        end
        rdc(STATUS_OFFSET, 32'h77);
        apb(1'b1, CTRL_OFFSET, 32'h0f);
        press(4'h1, 1'b1, 3'h3);
        drift <= 1'b1;
        press(4'h2, 1'b0, 3'h0);
        press(4'h8, 1'b0, 3'h0);
        drift <= 1'b0;
        rdc(STATUS_OFFSET, 32'h33);
        press(4'h2, 1'b1, 3'h0);
        press(4'h4, 1'b0, 3'h0);
        press(4'h2, 1'b1, 3'h0);
        for (int i = 1; i < 8; i++) press(4'h8, 1'b1, i[2:0]);
        press(4'h8, 1'b0, 3'h7);
        fault_stop <= 1'b1;
        press(4'h4, 1'b1, 3'h6);
        fault_stop <= 1'b0;
        apb(1'b1, CTRL_OFFSET, 32'h01);
        press(4'h8, 1'b0, 3'h6);
        digital_input[5] <= 1'b1;
        repeat (3) @(posedge pclk);
        apb(1'b1, ROUTE_OFFSET, 32'h5087);
        press(4'h0, 1'b0, 3'h0);
        rdc(ROUTE_OFFSET, 32'h5087);
        press(4'h1, 1'b0, 3'h0);
        apb(1'b1, CTRL_OFFSET, 32'h00);
        apb(1'b1, ROUTE_OFFSET, 32'h6087);
        press(4'h1, 1'b0, 3'h0);
        end_of_test();
    end
endmodule : tb_top
